// *** logic/rtc_pkg.sv ***
// package: register map, field layout, time bases and timing counts of the seconds counter
// How it works
// - all state but the event flag, enable and counter included, clears only on power-on reset.
// - four time bases: 1 Hz, delayed 1 Hz, 1 kHz or peripheral clock.
// - with the 1 Hz base the counter steps exactly once per second.
// - count_value reads the whole present 32-bit count in bits 31:0.
// - equality of count and compare value while running raises the masked interrupt event.
// - control bit 0 enables counting, 1 runs, 0 stops, reset value 0.
// - once enable is set, later writes to it are ignored until power-on reset.
// - reading control returns the present running status in bit 0.
// - interrupt_mask bit 0 written 1 enables, 0 masks; resets to 0.
// - reading interrupt_mask returns the mask setting in force.
// - mask bits 31:1 read zero; software writes zeros to unused bits.
// - raw status bit 0 reads the unmasked event flag; writes ignored.
// - masked status bit 0 reads flag and mask combined; writes ignored.
// - writing 1 to clear bit 0 clears the event flag; 0 leaves it.
package rtc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PRESET = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_RAW_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_MASKED_STATUS = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR = 12'h01C;

  localparam int CTRL_ENABLE_POS = 0;
  localparam int MASK_ENABLE_POS = 0;
  localparam int STATUS_EVENT_POS = 0;
  localparam int CLEAR_EVENT_POS = 0;

  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PRESET_RESET = 32'h0000_0000;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic MASK_RESET = 1'b0;
  localparam logic EVENT_RESET = 1'b0;

  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_1HZ_NS = 1_000_000_000;
  localparam int TICK_1KHZ_NS = 1_000_000;
  localparam int DELAYED_OFFSET_NS = 500_000_000;
  localparam int SEC_CYCLES = TICK_1HZ_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES = TICK_1KHZ_NS / CLK_PERIOD_NS;
  localparam int DELAY_CYCLES = DELAYED_OFFSET_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {tb_1hz, tb_1hz_delayed, tb_1khz, tb_pclk} timebase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// *** logic/tick_select.sv ***
// time-base generator: one-cycle tick at the rate of the selected source
`timescale 1ns/1ps
module tick_select #(
  parameter int SEC_CYCLES = rtc_pkg::SEC_CYCLES,
  parameter int MS_CYCLES = rtc_pkg::MS_CYCLES,
  parameter int DELAY_CYCLES = rtc_pkg::DELAY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input rtc_pkg::timebase_e clock_source_select,
  output logic tick
);

  localparam int SEC_W = $clog2(SEC_CYCLES);
  localparam int MS_W = $clog2(MS_CYCLES);

  logic [SEC_W-1:0] sec_cnt;
  logic [MS_W-1:0] ms_cnt;
  logic sec_wrap;
  logic ms_wrap;
  logic sec_delayed;
  logic next_tick;

  assign sec_wrap = sec_cnt == SEC_W'(SEC_CYCLES - 1);
  assign ms_wrap = ms_cnt == MS_W'(MS_CYCLES - 1);
  // delayed second lands a fixed offset into each second
  assign sec_delayed = sec_cnt == SEC_W'(DELAY_CYCLES - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= '0;
    end else if (sec_wrap) begin
      sec_cnt <= '0;
    end else begin
      sec_cnt <= sec_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
    end else if (ms_wrap) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  always_comb begin
    case (clock_source_select)
      rtc_pkg::tb_1hz: next_tick = sec_wrap;
      rtc_pkg::tb_1hz_delayed: next_tick = sec_delayed;
      rtc_pkg::tb_1khz: next_tick = ms_wrap;
      rtc_pkg::tb_pclk: next_tick = 1'b1;
      default: next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end

endmodule

// *** logic/seconds_counter_with_match.sv ***
// seconds counter with compare match, register slave and level interrupt
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module seconds_counter_with_match #(
  parameter int SEC_CYCLES = rtc_pkg::SEC_CYCLES,
  parameter int MS_CYCLES = rtc_pkg::MS_CYCLES,
  parameter int DELAY_CYCLES = rtc_pkg::DELAY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input rtc_pkg::reg_req_s req,
  output logic [rtc_pkg::DATA_W-1:0] rdata,
  input rtc_pkg::timebase_e clock_source_select,
  output logic counter_running,
  output logic irq
);

  generate
    if (SEC_CYCLES < 2) begin : g_bad_sec
      $error("SEC_CYCLES must be at least 2");
    end
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
    if (DELAY_CYCLES < 1 || DELAY_CYCLES > SEC_CYCLES) begin : g_bad_delay
      $error("DELAY_CYCLES must lie within one second");
    end
  endgenerate

  typedef enum logic [1:0] {st_stopped, st_load, st_running} run_state_e;

  localparam int DW = rtc_pkg::DATA_W;

  // rst_n is the power-on reset; no other reset reaches this block
  run_state_e state;
  run_state_e next_state;

  logic [DW-1:0] count;
  logic [DW-1:0] compare;
  logic [DW-1:0] preset;
  logic enable;
  logic int_mask;
  logic event_flag;
  logic match_prev;
  logic tick;

  logic wr_compare;
  logic wr_preset;
  logic wr_control;
  logic wr_mask;
  logic wr_clear;
  logic start_req;
  logic clear_req;
  logic match_now;
  logic match_rise;
  logic [DW-1:0] next_rdata;

  // a write strobe hits one register when the address matches its offset
  function automatic logic hit(input rtc_pkg::reg_req_s r,
                               input logic [rtc_pkg::ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // one-bit field placed at its position in an otherwise zero word
  function automatic logic [DW-1:0] place(input logic b, input int pos);
    logic [DW-1:0] w;
    w = '0;
    w[pos] = b;
    place = w;
  endfunction

  tick_select #(
    .SEC_CYCLES(SEC_CYCLES),
    .MS_CYCLES(MS_CYCLES),
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clock_source_select(clock_source_select),
    .tick(tick)
  );

  // write decode
  assign wr_compare = hit(req, rtc_pkg::OFS_COMPARE);
  assign wr_preset = hit(req, rtc_pkg::OFS_PRESET);
  assign wr_control = hit(req, rtc_pkg::OFS_CONTROL);
  assign wr_mask = hit(req, rtc_pkg::OFS_MASK);
  assign wr_clear = hit(req, rtc_pkg::OFS_EVENT_CLEAR);

  // only a stopped counter listens to the enable bit
  assign start_req = wr_control && req.wdata[rtc_pkg::CTRL_ENABLE_POS] &&
                     (state == st_stopped);
  assign clear_req = wr_clear && req.wdata[rtc_pkg::CLEAR_EVENT_POS];

  // run control
  always_comb begin
    next_state = state;
    case (state)
      st_stopped: begin
        if (start_req) begin
          next_state = st_load;
        end
      end
      st_load: begin
        next_state = st_running;
      end
      st_running: begin
        next_state = st_running;
      end
      default: begin
        next_state = st_stopped;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_stopped;
    end else begin
      state <= next_state;
    end
  end

  // enable bit: set once, held until power-on reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable <= rtc_pkg::ENABLE_RESET;
    end else if (start_req) begin
      enable <= 1'b1;
    end
  end

  assign counter_running = enable;

  // counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= rtc_pkg::COUNT_RESET;
    end else if (state == st_load) begin
      count <= preset;
    end else if (state == st_running && tick) begin
      count <= count + 1'b1;
    end
  end

  // compare value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare <= rtc_pkg::COMPARE_RESET;
    end else if (wr_compare) begin
      compare <= req.wdata;
    end
  end

  // preset value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preset <= rtc_pkg::PRESET_RESET;
    end else if (wr_preset) begin
      preset <= req.wdata;
    end
  end

  // interrupt mask, only bit 0 is stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= rtc_pkg::MASK_RESET;
    end else if (wr_mask) begin
      int_mask <= req.wdata[rtc_pkg::MASK_ENABLE_POS];
    end
  end

  // equality is taken once per arrival so a standing match can be cleared
  assign match_now = (state == st_running) && (count == compare);
  assign match_rise = match_now && !match_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match_now;
    end
  end

  // sticky event flag; a new match beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_flag <= rtc_pkg::EVENT_RESET;
    end else if (match_rise) begin
      event_flag <= 1'b1;
    end else if (clear_req) begin
      event_flag <= 1'b0;
    end
  end

  assign irq = event_flag & int_mask;

  // read mux; unmapped addresses and unused bits read zero
  always_comb begin
    next_rdata = '0;
    case (req.addr)
      rtc_pkg::OFS_COUNT: begin
        next_rdata = count;
      end
      rtc_pkg::OFS_COMPARE: begin
        next_rdata = compare;
      end
      rtc_pkg::OFS_PRESET: begin
        next_rdata = preset;
      end
      rtc_pkg::OFS_CONTROL: begin
        next_rdata = place(enable, rtc_pkg::CTRL_ENABLE_POS);
      end
      rtc_pkg::OFS_MASK: begin
        next_rdata = place(int_mask, rtc_pkg::MASK_ENABLE_POS);
      end
      rtc_pkg::OFS_RAW_STATUS: begin
        next_rdata = place(event_flag, rtc_pkg::STATUS_EVENT_POS);
      end
      rtc_pkg::OFS_MASKED_STATUS: begin
        next_rdata = place(irq, rtc_pkg::STATUS_EVENT_POS);
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule

// *** sim/seconds_counter_with_match_assertions.sv ***
// checker: port-level assertions for the seconds counter
`timescale 1ns/1ps
module seconds_counter_with_match_assertions #(
  parameter int SEC_CYCLES = 1,
  parameter int MS_CYCLES = 1,
  parameter int DELAY_CYCLES = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input rtc_pkg::reg_req_s req,
  input wire logic [rtc_pkg::DATA_W-1:0] rdata,
  input rtc_pkg::timebase_e clock_source_select,
  input wire logic counter_running,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  start_run_a:
  assert property (req.wr && req.addr == rtc_pkg::OFS_CONTROL && req.wdata[0] |=> counter_running)
    else $error("enable write did not start the counter");
  run_sticky_a:
  assert property (counter_running |=> counter_running) else $error("counter stopped after enable");
  control_read_a:
  assert property (req.rd && req.addr == rtc_pkg::OFS_CONTROL
    |=> rdata == {31'h0, $past(counter_running)}) else $error("control read wrong");
  mask_read_a:
  assert property (req.rd && req.addr == rtc_pkg::OFS_MASK |=> rdata[31:1] == 31'h0)
    else $error("mask upper bits not zero");
  masked_read_a:
  assert property (req.rd && req.addr == rtc_pkg::OFS_MASKED_STATUS
    |=> rdata == {31'h0, $past(irq)}) else $error("masked status differs from irq");
  raw_read_a:
  assert property (req.rd && req.addr == rtc_pkg::OFS_RAW_STATUS && irq |=> rdata == 32'h1)
    else $error("raw flag low while irq high");
  idle_count_a:
  assert property (req.rd && req.addr == rtc_pkg::OFS_COUNT && !counter_running
    |=> rdata == 32'h0) else $error("count moved before enable");
  irq_hold_a:
  assert property (irq && !(req.wr && (req.addr == rtc_pkg::OFS_EVENT_CLEAR
    || req.addr == rtc_pkg::OFS_MASK)) |=> irq) else $error("irq dropped without clear");
  irq_quiet_a:
  assert property (!counter_running |-> !irq) else $error("irq while stopped");
endmodule
bind seconds_counter_with_match seconds_counter_with_match_assertions #(
  .SEC_CYCLES(SEC_CYCLES), .MS_CYCLES(MS_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)
) u_seconds_counter_with_match_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
  .clock_source_select(clock_source_select), .counter_running(counter_running), .irq(irq));

// *** sim/seconds_counter_with_match_bench.sv ***
// testbench: register table walk, time bases, enable lock, interrupt mask and clear
`timescale 1ns/1ps
module seconds_counter_with_match_bench;
  typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data;} row_s;
  localparam int SEC = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  rtc_pkg::reg_req_s req = '0;
  rtc_pkg::timebase_e src = rtc_pkg::tb_pclk;
  logic [31:0] rdata, v, a;
  logic counter_running, irq;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int per[4] = '{SEC, SEC, 5, 1};
  // reads carry the expected value, writes the data written
  // unused mask and control bits are always written as zero
  row_s rows[22] = '{
    '{1'b0, 12'h000, 32'h0}, '{1'b0, 12'h004, 32'h0}, '{1'b0, 12'h008, 32'h0},
    '{1'b0, 12'h00C, 32'h0}, '{1'b0, 12'h010, 32'h0}, '{1'b0, 12'h014, 32'h0},
    '{1'b0, 12'h018, 32'h0},
    '{1'b1, 12'h004, 32'hA5A5_5A5A}, '{1'b0, 12'h004, 32'hA5A5_5A5A},
    '{1'b1, 12'h008, 32'h1234_5678}, '{1'b0, 12'h008, 32'h1234_5678},
    '{1'b1, 12'h010, 32'h1}, '{1'b0, 12'h010, 32'h1}, '{1'b1, 12'h010, 32'h0},
    '{1'b0, 12'h010, 32'h0}, '{1'b1, 12'h00C, 32'h0}, '{1'b0, 12'h00C, 32'h0},
    '{1'b1, 12'h000, 32'hFFFF_FFFF}, '{1'b0, 12'h000, 32'h0}, '{1'b1, 12'h014, 32'h1},
    '{1'b0, 12'h014, 32'h0}, '{1'b0, 12'h020, 32'h0}};

  seconds_counter_with_match #(.SEC_CYCLES(SEC), .MS_CYCLES(5), .DELAY_CYCLES(10))
    u_seconds_counter_with_match (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
    .clock_source_select(src), .counter_running(counter_running), .irq(irq));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{ad, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] ad);
    @(posedge clk_sys);
    req.addr <= ad;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("outputs in reset", rdata | {counter_running, irq}, 32'h0);
    rst_n <= 1'b1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("[ERR] cycles expected below %0d seen %0d", cycles, cycles);
      end_of_test();
    end
  end

  initial begin
    do_reset();
    for (int i = 0; i < 22; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        rd(rows[i].addr);
        check($sformatf("reg %h", rows[i].addr), v, rows[i].data);
      end
    end
    $display("register table test done");
    for (int s = 0; s < 4; s++) begin
      do_reset();
      src <= rtc_pkg::timebase_e'(s);
      // first count read after reset is thrown away
      rd(rtc_pkg::OFS_COUNT);
      rd(rtc_pkg::OFS_CONTROL);
      check("control after reset", v, 32'h0);
      wr(rtc_pkg::OFS_COMPARE, 32'h0000_0002);
      wr(rtc_pkg::OFS_PRESET, 32'hFFFF_FFF0);
      wr(rtc_pkg::OFS_MASK, 32'h1);
      wr(rtc_pkg::OFS_CONTROL, 32'h1);
      rd(rtc_pkg::OFS_COUNT);
      a = v;
      repeat (38) @(posedge clk_sys);
      rd(rtc_pkg::OFS_COUNT);
      check("count step", v - a, 32'(2 * SEC / per[s]));
      check("running flag", counter_running, 32'h1);
      $display("time base %0d test done", s);
    end
    // peripheral clock has wrapped past the compare value by now
    check("irq after match", irq, 32'h1);
    wr(rtc_pkg::OFS_MASK, 32'h0);
    rd(rtc_pkg::OFS_MASKED_STATUS);
    check("masked status", v, 32'h0);
    check("irq masked", irq, 32'h0);
    rd(rtc_pkg::OFS_RAW_STATUS);
    check("raw status", v, 32'h1);
    wr(rtc_pkg::OFS_MASK, 32'h1);
    rd(rtc_pkg::OFS_MASKED_STATUS);
    check("masked status", v, 32'h1);
    wr(rtc_pkg::OFS_EVENT_CLEAR, 32'h0);
    rd(rtc_pkg::OFS_RAW_STATUS);
    check("flag after zero clear", v, 32'h1);
    wr(rtc_pkg::OFS_CONTROL, 32'h0);
    rd(rtc_pkg::OFS_CONTROL);
    check("control locked", v, 32'h1);
    wr(rtc_pkg::OFS_EVENT_CLEAR, 32'h1);
    rd(rtc_pkg::OFS_RAW_STATUS);
    check("flag after clear", v, 32'h0);
    check("irq after clear", irq, 32'h0);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
